// *** verilog/pldc_pkg.sv ***
// Constants, types and register map of the power-loss deceleration control.
package pldc_pkg;

    // ****************************************************************
    // Widths and scaling
    // ****************************************************************
    localparam int VW = 14;    // Bus voltage, 0.1 V per count.
    localparam int FW = 16;    // Frequency, 0.01 Hz per count.
    localparam int TW = 19;    // Decel time, 0.01 s per count.
    localparam int AW = 20;    // Rate accumulator width.
    localparam int EW = 4;     // Number of interrupt events.

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_TRIG  = 8'h04;
    localparam logic [7:0] OFS_OVTH  = 8'h08;
    localparam logic [7:0] OFS_DTIME = 8'h0c;
    localparam logic [7:0] OFS_STEP  = 8'h10;
    localparam logic [7:0] OFS_STAT  = 8'h14;
    localparam logic [7:0] OFS_ISTAT = 8'h18;
    localparam logic [7:0] OFS_IMASK = 8'h1c;

    // ****************************************************************
    // Control fields, codes, limits and reset values
    // ****************************************************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SKEY_BIT = 2;
    localparam int CTRL_RTRY_BIT = 3;
    localparam int STAT_ST_LSB   = 16;
    localparam logic [1:0] MODE_DISABLE = 2'h0;
    localparam logic [1:0] MODE_ENABLE  = 2'h1;
    localparam logic [VW-1:0] VOLT_MAX  = 14'h2710;  // 1000.0 V.
    localparam logic [FW-1:0] STEP_MAX  = 16'h03e8;  // 10.00 Hz.
    localparam logic [TW-1:0] DTIME_MIN = 19'h00001; // 0.01 s.
    localparam logic [TW-1:0] DTIME_MAX = 19'h57e40; // 3600 s.
    localparam logic [VW-1:0] TRIG_RST  = 14'h0000;
    localparam logic [VW-1:0] OVTH_RST  = 14'h0000;
    localparam logic [TW-1:0] DTIME_RST = 19'h00064; // 1.00 s.
    localparam logic [FW-1:0] STEP_RST  = 16'h0000;
    localparam logic [FW-1:0] FMAX_DEF  = 16'h1770;  // 60.00 Hz.

    // ****************************************************************
    // Timing: the rate base is a 10 ms tick
    // ****************************************************************
    localparam int TICK_NS  = 10000000;
    localparam int CLK_NS   = 20;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int RETRY_TK = 100;

    // ****************************************************************
    // Interrupt event bits
    // ****************************************************************
    localparam int EV_START = 0;
    localparam int EV_DONE  = 1;
    localparam int EV_TRIP  = 2;
    localparam int EV_COAST = 3;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_RUN   = 8'h02,
        ST_STEP  = 8'h04,
        ST_DECEL = 8'h08,
        ST_HOLD  = 8'h10,
        ST_DONE  = 8'h20,
        ST_TRIP  = 8'h40,
        ST_COAST = 8'h80
    } pldc_state_t;

    typedef struct packed {
        logic [VW-1:0] vbus;
        logic          uv;
        logic          pwr_ok;
        logic          run_cmd;
        logic          trip;
        logic          alarm_rst;
        logic          stop_key;
        logic [FW-1:0] freq_cmd;
    } pldc_drv_in_t;

    typedef struct packed {
        logic [FW-1:0] freq;
        logic          run_en;
        logic          coast;
        logic          decel;
    } pldc_drv_out_t;

endpackage

// *** verilog/pldc_top.sv ***
// Power-loss deceleration and restart supervisor with an APB register file.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Mode field: code 00 disables, code 01 enables power-loss deceleration.
// - Deceleration starts when falling bus voltage reaches trigger level.
// - Entry first lowers output frequency by a step of up to 10 Hz.
// - Then frequency falls linearly at a dedicated power-loss decel time.
// - Bus above over-voltage threshold holds output frequency constant.
// - Bus back below threshold resumes decel, repeating until under-voltage.
// - A started sequence runs to stop even if input power returns.
// - Power back at sequence end re-enables run mode automatically.
// - Feature disabled: power loss shuts down at once, motor coasts.
// - After a short interruption, run resumes if run command remains.
// - Alarm reset during a trip with run command present restarts.
// - Power applied with run command asserted starts the motor.
// - Stop key disabled: key neither stops nor resets a trip.
// - Retry mode restarts the motor by itself after a trip stop.
module pldc_top
    import pldc_pkg::*;
#(
    parameter int          TICK_CYCLES = TICK_CYC,
    parameter int          RETRY_TICKS = RETRY_TK,
    parameter logic [FW-1:0] FMAX      = FMAX_DEF
)(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire pldc_drv_in_t  drv_in,
    output pldc_drv_out_t      drv_out,
    output logic               irq
);

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        pldc_state_t     st;
        logic [FW-1:0]   freq;
        logic [AW-1:0]   acc;
        logic [19:0]     tcnt;
        logic [15:0]     rcnt;
        logic            stop_lat;
        logic [1:0]      mode;
        logic            skey_en;
        logic            rtry_en;
        logic [VW-1:0]   trig;
        logic [VW-1:0]   ovth;
        logic [TW-1:0]   dtime;
        logic [FW-1:0]   step;
        logic [EW-1:0]   istat;
        logic [EW-1:0]   imask;
        logic [31:0]     rdata;
    } pldc_reg_t;

    pldc_reg_t q_r;
    pldc_reg_t q_nxt;

    // Clamp a written value into its legal range.
    function automatic logic [31:0] clamp(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // ****************************************************************
    // Bus decode and status word
    // ****************************************************************
    logic        setup;
    logic        wr_acc;
    logic        mapped;
    logic        tick;
    logic        en_mode;
    logic [EW-1:0] ev;
    logic        go_run;

    // Reads are latched in the setup cycle, so no wait states occur.
    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & pwrite & mapped;
    assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= OFS_IMASK);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = q_r.rdata;
    assign tick    = (q_r.tcnt == 20'(TICK_CYCLES - 1));
    assign en_mode = (q_r.mode == MODE_ENABLE);
    assign irq     = |(q_r.istat & q_r.imask);
    // Run is allowed only with power, a run command, no trip and no stop latch.
    assign go_run  = drv_in.run_cmd & drv_in.pwr_ok & ~drv_in.trip
                   & ~q_r.stop_lat;
    assign drv_out.freq   = q_r.freq;
    assign drv_out.run_en = (q_r.st == ST_RUN);
    assign drv_out.coast  = (q_r.st == ST_COAST);
    assign drv_out.decel  = (q_r.st == ST_STEP) | (q_r.st == ST_DECEL)
                          | (q_r.st == ST_HOLD);

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        q_nxt = q_r;
        ev    = '0;
        q_nxt.tcnt = tick ? 20'h00000 : q_r.tcnt + 20'h00001;
        if (!drv_in.run_cmd)
        begin
            q_nxt.stop_lat = 1'b0;
        end
        case (q_r.st)
            ST_IDLE:
            begin
                q_nxt.freq = '0;
                if (go_run)
                begin
                    q_nxt.st = ST_RUN;
                end
            end
            ST_RUN:
            begin
                q_nxt.freq = drv_in.freq_cmd;
                if (!drv_in.pwr_ok && !en_mode)
                begin
                    // Control power is gone; no alarm is raised here.
                    q_nxt.st   = ST_COAST;
                    q_nxt.freq = '0;
                    ev[EV_COAST] = 1'b1;
                end
                else if (!drv_in.pwr_ok)
                begin
                    // Keep running until the bus decays to the trigger.
                    if (drv_in.vbus <= q_r.trig)
                    begin
                        q_nxt.st  = ST_STEP;
                        q_nxt.freq = q_r.freq;
                        ev[EV_START] = 1'b1;
                    end
                end
                else if (drv_in.trip)
                begin
                    q_nxt.st   = ST_TRIP;
                    q_nxt.freq = '0;
                    q_nxt.rcnt = '0;
                    ev[EV_TRIP] = 1'b1;
                end
                else if (drv_in.stop_key && q_r.skey_en)
                begin
                    q_nxt.st       = ST_IDLE;
                    q_nxt.stop_lat = 1'b1;
                end
                else if (!drv_in.run_cmd)
                begin
                    q_nxt.st = ST_IDLE;
                end
            end
            ST_STEP:
            begin
                // One-shot step drop, saturating at zero.
                q_nxt.freq = (q_r.freq > q_r.step) ?
                             q_r.freq - q_r.step : '0;
                q_nxt.acc  = '0;
                q_nxt.st   = ST_DECEL;
            end
            ST_DECEL:
            begin
                if (drv_in.uv || q_r.freq == '0)
                begin
                    q_nxt.st   = ST_DONE;
                    q_nxt.freq = '0;
                    ev[EV_DONE] = 1'b1;
                end
                else if (drv_in.vbus > q_r.ovth)
                begin
                    q_nxt.st = ST_HOLD;
                end
                else
                begin
                    // FMAX/dtime counts per tick, spread one per cycle.
                    if (q_r.acc >= AW'(q_r.dtime))
                    begin
                        q_nxt.freq = q_r.freq - 16'h0001;
                        q_nxt.acc  = q_r.acc - AW'(q_r.dtime);
                    end
                    else if (tick)
                    begin
                        q_nxt.acc = q_r.acc + AW'(FMAX);
                    end
                end
            end
            ST_HOLD:
            begin
                if (drv_in.uv)
                begin
                    q_nxt.st   = ST_DONE;
                    q_nxt.freq = '0;
                    ev[EV_DONE] = 1'b1;
                end
                else if (drv_in.vbus <= q_r.ovth)
                begin
                    q_nxt.st = ST_DECEL;
                end
            end
            ST_DONE:
            begin
                // Power back after the stop lets run mode resume.
                q_nxt.freq = '0;
                if (drv_in.pwr_ok)
                begin
                    q_nxt.st = ST_IDLE;
                end
            end
            ST_TRIP:
            begin
                q_nxt.freq = '0;
                if (tick && q_r.rcnt != 16'(RETRY_TICKS))
                begin
                    q_nxt.rcnt = q_r.rcnt + 16'h0001;
                end
                if (!drv_in.trip && (drv_in.alarm_rst
                    || (drv_in.stop_key && q_r.skey_en)
                    || (q_r.rtry_en
                        && q_r.rcnt == 16'(RETRY_TICKS))))
                begin
                    q_nxt.st = ST_IDLE;
                end
            end
            ST_COAST:
            begin
                q_nxt.freq = '0;
                if (drv_in.pwr_ok)
                begin
                    q_nxt.st = ST_IDLE;
                end
            end
            default:
            begin
                q_nxt.st   = ST_IDLE;
                q_nxt.freq = '0;
            end
        endcase

        // Register writes; hardware set wins over a write-one clear.
        if (wr_acc)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    q_nxt.mode    = pwdata[CTRL_MODE_LSB +: 2];
                    q_nxt.skey_en = pwdata[CTRL_SKEY_BIT];
                    q_nxt.rtry_en = pwdata[CTRL_RTRY_BIT];
                end
                OFS_TRIG:  q_nxt.trig  = VW'(clamp(pwdata, '0,
                                             32'(VOLT_MAX)));
                OFS_OVTH:  q_nxt.ovth  = VW'(clamp(pwdata, '0,
                                             32'(VOLT_MAX)));
                OFS_DTIME: q_nxt.dtime = TW'(clamp(pwdata,
                                  32'(DTIME_MIN), 32'(DTIME_MAX)));
                OFS_STEP:  q_nxt.step  = FW'(clamp(pwdata, '0,
                                             32'(STEP_MAX)));
                OFS_ISTAT: q_nxt.istat = q_r.istat & ~pwdata[EW-1:0];
                OFS_IMASK: q_nxt.imask = pwdata[EW-1:0];
                default:   q_nxt.rdata = q_r.rdata;
            endcase
        end
        q_nxt.istat = q_nxt.istat | ev;

        // Read data is captured in the setup cycle.
        if (setup && !pwrite)
        begin
            case (paddr)
                OFS_CTRL:  q_nxt.rdata = 32'({q_r.rtry_en, q_r.skey_en,
                                              q_r.mode});
                OFS_TRIG:  q_nxt.rdata = 32'(q_r.trig);
                OFS_OVTH:  q_nxt.rdata = 32'(q_r.ovth);
                OFS_DTIME: q_nxt.rdata = 32'(q_r.dtime);
                OFS_STEP:  q_nxt.rdata = 32'(q_r.step);
                OFS_STAT:  q_nxt.rdata = {8'h00, q_r.st, q_r.freq};
                OFS_ISTAT: q_nxt.rdata = 32'(q_r.istat);
                OFS_IMASK: q_nxt.rdata = 32'(q_r.imask);
                default:   q_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            q_r       <= '0;
            q_r.st    <= ST_IDLE;
            q_r.trig  <= TRIG_RST;
            q_r.ovth  <= OVTH_RST;
            q_r.dtime <= DTIME_RST;
            q_r.step  <= STEP_RST;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_loss;
        q_r.st == ST_RUN && !drv_in.pwr_ok && en_mode
        && drv_in.vbus <= q_r.trig;
    endsequence

    sequence s_entry;
        q_r.st == ST_STEP ##1 q_r.st == ST_DECEL;
    endsequence

    AST_TRIGGER: assert property (s_loss |=> s_entry)
        else $error("Decel did not start at trigger level.");
    AST_STEP: assert property (q_r.st == ST_STEP |=>
        q_r.freq == (($past(q_r.freq) > q_r.step) ?
                     $past(q_r.freq) - q_r.step : 16'h0000))
        else $error("Initial frequency step wrong.");
    AST_RATE: assert property (q_r.st == ST_DECEL && !drv_in.uv
        && q_r.freq != '0 && drv_in.vbus <= q_r.ovth
        && q_r.acc >= AW'(q_r.dtime)
        |=> q_r.freq == $past(q_r.freq) - 16'h0001)
        else $error("Linear decel step missing.");
    AST_HOLD: assert property (q_r.st == ST_HOLD && !drv_in.uv
        && drv_in.vbus > q_r.ovth |=> $stable(q_r.freq)
        && q_r.st == ST_HOLD)
        else $error("Frequency moved during hold.");
    AST_RESUME: assert property (q_r.st == ST_HOLD && !drv_in.uv
        && drv_in.vbus <= q_r.ovth |=> q_r.st == ST_DECEL)
        else $error("Decel did not resume.");
    AST_NOABORT: assert property (drv_out.decel |=> drv_out.decel
        || q_r.st == ST_DONE)
        else $error("Sequence left before stop.");
    AST_REARM: assert property (q_r.st == ST_DONE && drv_in.pwr_ok
        |=> q_r.st == ST_IDLE ##1 (!$past(go_run) || q_r.st == ST_RUN))
        else $error("Run mode not re-enabled.");
    AST_COAST: assert property (q_r.st == ST_RUN && !drv_in.pwr_ok
        && !en_mode |=> drv_out.coast && q_r.freq == '0
        && q_r.istat[EV_COAST])
        else $error("Disabled loss did not coast.");
    AST_START: assert property (q_r.st == ST_IDLE && go_run
        |=> drv_out.run_en)
        else $error("Run command did not start motor.");
    AST_ALMRST: assert property (q_r.st == ST_TRIP && !drv_in.trip
        && drv_in.alarm_rst |=> q_r.st == ST_IDLE)
        else $error("Alarm reset ignored.");
    AST_SKEY: assert property (q_r.st == ST_TRIP && !q_r.skey_en
        && !drv_in.alarm_rst && !q_r.rtry_en |=> q_r.st == ST_TRIP)
        else $error("Disabled stop key left trip.");
    AST_UV: assert property (drv_out.decel && q_r.st != ST_STEP
        && drv_in.uv |=> q_r.st == ST_DONE && q_r.freq == '0)
        else $error("Under-voltage did not end sequence.");

endmodule

`default_nettype wire

// *** dv/pldc_bus_model.sv ***
// Behavioural model of the power stage and the bus voltage sensing.
`timescale 1ns/1ps
`default_nettype none
module pldc_bus_model
    import pldc_pkg::*;
#(
    parameter logic [VW-1:0] NOM   = 14'h0bb8,
    parameter logic [VW-1:0] SURGE = 14'h0fa0,
    parameter logic [VW-1:0] UVL   = 14'h07d0,
    parameter logic [VW-1:0] DECAY = 14'h0001
)(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          mains_on,
    input  wire logic          regen,
    output logic [VW-1:0]      vbus,
    output logic               uv,
    output logic               pwr_ok
);
    // The bus sits at nominal on mains and sags slowly without it.
    // Hard regeneration throws it up to SURGE, as a heavy load would.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            vbus <= NOM;
        else if (regen)
            vbus <= SURGE;
        else if (mains_on)
            vbus <= NOM;
        else if (vbus > DECAY)
            vbus <= vbus - DECAY;
        else
            vbus <= '0;
    end
    // Plain comparator; no hysteresis, so the level must not chatter.
    assign uv     = (vbus < UVL);
    assign pwr_ok = mains_on;
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the power-loss deceleration supervisor.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pldc_pkg::*;
;
    logic          mclk = 1'b0;
    logic          rst = 1'b1;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
    logic          mains_on = 1'b1;
    logic          regen = 1'b0;
    logic          run_cmd = 1'b1;
    logic          trip = 1'b0;
    logic          alarm_rst = 1'b0;
    logic          stop_key = 1'b0;
    logic [FW-1:0] freq_cmd = 16'h03e8;
    logic [VW-1:0] vbus;
    logic          uv;
    logic          pwr_ok;
    pldc_drv_in_t  drv_in;
    pldc_drv_out_t drv_out;
    int            err_count = 0;
    int            n_compared = 0;
    int            i;
    logic [31:0]   rd;
    logic          rerr;
    logic [FW-1:0] f0;

    always #10 mclk = ~mclk;
    assign drv_in = {vbus, uv, pwr_ok, run_cmd, trip, alarm_rst, stop_key,
                     freq_cmd};

    // Short tick and retry counts keep the run brief.
    pldc_top #(.TICK_CYCLES(10), .RETRY_TICKS(3), .FMAX(16'h0064)) pldc_top_i (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .drv_in(drv_in),
        .drv_out(drv_out), .irq(irq));
    pldc_bus_model pldc_bus_model_i (
        .mclk(mclk), .rst(rst), .mains_on(mains_on), .regen(regen),
        .vbus(vbus), .uv(uv), .pwr_ok(pwr_ok));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One APB transfer; only the watchdog ends a wait for pready.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd      = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, OFS_DTIME, 32'h0);
        chk("dtime reset", {13'h0, DTIME_RST}, rd);
        apb(1'b1, OFS_STEP, 32'h0000ffff);
        apb(1'b0, OFS_STEP, 32'h0);
        chk("step clamp", {16'h0, STEP_MAX}, rd);
        apb(1'b1, OFS_DTIME, 32'h0);
        apb(1'b0, OFS_DTIME, 32'h0);
        chk("dtime clamp", {13'h0, DTIME_MIN}, rd);
        chk("pready", 32'h1, {31'h0, pready});
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped slverr", 32'h1, {31'h0, rerr});
        chk("power on run", 32'h1, {31'h0, drv_out.run_en});
        chk("run freq", {16'h0, freq_cmd}, {16'h0, drv_out.freq});
        $display("t_regs finished");
    endtask

    task automatic t_coast();
        mains_on <= 1'b0;
        cyc(4);
        chk("coast", 32'h1, {31'h0, drv_out.coast});
        chk("coast freq", 32'h0, {16'h0, drv_out.freq});
        mains_on <= 1'b1;
        cyc(6);
        chk("run after dip", 32'h1, {31'h0, drv_out.run_en});
        $display("t_coast finished");
    endtask

    task automatic t_decel();
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl mode", 32'h1, rd);
        apb(1'b1, OFS_TRIG, 32'h0af0);
        apb(1'b1, OFS_OVTH, 32'h0c80);
        apb(1'b1, OFS_DTIME, 32'h14);
        apb(1'b1, OFS_STEP, 32'h64);
        apb(1'b1, OFS_IMASK, 32'h1);
        mains_on <= 1'b0;
        for (i = 0; i < 400 && drv_out.decel !== 1'b1; i++)
            @(posedge mclk);
        chk("trigger level", 32'h0aef, {18'h0, vbus});
        @(posedge mclk);
        chk("first step", 32'h0384, {16'h0, drv_out.freq});
        f0 = drv_out.freq;
        cyc(200);
        chk("decel rate", 32'h1, {31'h0, (f0 - drv_out.freq)
            inside {[16'h005a:16'h006e]}});
        chk("irq on start", 32'h1, {31'h0, irq});
        apb(1'b1, OFS_ISTAT, 32'h1);
        @(posedge mclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        mains_on <= 1'b1;
        cyc(20);
        chk("decel kept", 32'h1, {31'h0, drv_out.decel});
        mains_on <= 1'b0;
        regen    <= 1'b1;
        cyc(4);
        f0 = drv_out.freq;
        cyc(8);
        chk("hold freq", {16'h0, f0}, {16'h0, drv_out.freq});
        regen <= 1'b0;
        cyc(900);
        chk("resumed", 32'h1, {31'h0, drv_out.freq < f0});
        for (i = 0; i < 3000 && drv_out.decel !== 1'b0; i++)
            @(posedge mclk);
        chk("stop freq", 32'h0, {16'h0, drv_out.freq});
        mains_on <= 1'b1;
        cyc(6);
        chk("run again", 32'h1, {31'h0, drv_out.run_en});
        $display("t_decel finished");
    endtask

    task automatic t_trip();
        stop_key <= 1'b1;
        cyc(5);
        chk("key in run", 32'h1, {31'h0, drv_out.run_en});
        trip     <= 1'b1;
        stop_key <= 1'b0;
        cyc(4);
        chk("trip stops", 32'h0, {31'h0, drv_out.run_en});
        trip     <= 1'b0;
        stop_key <= 1'b1;
        cyc(20);
        chk("key in trip", 32'h0, {31'h0, drv_out.run_en});
        stop_key  <= 1'b0;
        alarm_rst <= 1'b1;
        cyc(5);
        chk("alarm reset", 32'h1, {31'h0, drv_out.run_en});
        alarm_rst <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h9);
        trip <= 1'b1;
        cyc(4);
        trip <= 1'b0;
        cyc(3);
        chk("retry wait", 32'h0, {31'h0, drv_out.run_en});
        cyc(60);
        chk("retry run", 32'h1, {31'h0, drv_out.run_en});
        // With the key enabled it stops the motor and latches until the
        // run command is dropped, so a held command cannot restart it.
        apb(1'b1, OFS_CTRL, 32'h5);
        stop_key <= 1'b1;
        cyc(3);
        stop_key <= 1'b0;
        cyc(3);
        chk("key stops", 32'h0, {31'h0, drv_out.run_en});
        run_cmd <= 1'b0;
        cyc(2);
        run_cmd <= 1'b1;
        cyc(3);
        chk("run after key", 32'h1, {31'h0, drv_out.run_en});
        $display("t_trip finished");
    endtask

    // Main sequence; the watchdog below ends a hang in the same place.
    initial
    begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_coast();
        t_decel();
        t_trip();
        conclude();
    end

    initial
    begin
        #400000;
        $display("[ERR] watchdog expected done seen timeout");
        err_count++;
        conclude();
    end
endmodule
`default_nettype wire
